// ---- tfa_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the frame timing block.
`ifndef TFA_CFG_SVH
`define TFA_CFG_SVH

// One timing tick is one half period of the fastest output clock (32.768 MHz).
`define TFA_FRAME_US 125
`define TFA_TICK_KHZ 65536
`define TFA_FRAME_TICKS (`TFA_FRAME_US * `TFA_TICK_KHZ / 1000)

// Register word addresses on the 14-bit register port.
`define TFA_ADDR_CR 14'h0000
`define TFA_ADDR_IMS 14'h0001
`define TFA_ADDR_OUT_CLK_FRAME_SELECT_REG 14'h0002
`define TFA_ADDR_STATUS 14'h0003
`define TFA_ADDR_STREAM_INPUT_CONTROL 14'h0100
`define TFA_ADDR_STREAM_OUTPUT_CONTROL 14'h0200

// Control register fields.
`define TFA_CR_RATE_LO 5
`define TFA_CR_INPOL 7
`define TFA_CR_INPOS 9
`define TFA_CR_DIV 10

// Clock and frame output selection fields, one bit per output in each group except the 2-bit rate select of output 3.
`define TFA_OC_CKPOL_LO 0
`define TFA_OC_FPPOL_LO 4
`define TFA_OC_FPPOS_LO 8
`define TFA_OC_SEL3_LO 12

// Mode selection enable fields.
`define TFA_IMS_FPEN_LO 8
`define TFA_IMS_CKEN_LO 12

// Stream control fields.
`define TFA_SC_RATE_LO 0
`define TFA_SI_SMP_LO 4
`define TFA_SI_BD_LO 6
`define TFA_SO_AD_LO 4
`define TFA_SO_FA_LO 7
`define TFA_SO_HZ_LO 9

// Reset values and writable bits.
`define TFA_CR_RST 16'h0000
`define TFA_IMS_RST 16'hFF00
`define TFA_OUT_CLK_FRAME_SELECT_REG_RST 16'h0000
`define TFA_STREAM_INPUT_CONTROL_RST 16'h0020
`define TFA_STREAM_OUTPUT_CONTROL_RST 16'h0000
`define TFA_STREAM_INPUT_CONTROL_MASK 16'h01FF
`define TFA_STREAM_OUTPUT_CONTROL_MASK 16'h0FFF

`endif

// ---- tfa_pkg.sv ----
// Types shared by the frame timing block and its users.
package tfa_pkg;

   typedef struct packed {
      logic cs;
      logic wr;
      logic [13:0] addr;
      logic [15:0] wdata;
   } tfa_reg_req_t;

   typedef struct packed {
      logic [3:0] clk;
      logic [3:0] clk_oe;
      logic [3:0] fp;
      logic [3:0] fp_oe;
   } tfa_tim_pins_t;

   typedef struct packed {
      logic [4:0] stream;
      logic [7:0] chan;
      logic [7:0] data;
   } tfa_rx_word_t;

   typedef enum logic [2:0] {
      RK_NONE,
      RK_CR,
      RK_IMS,
      RK_OUT_CLK_FRAME_SELECT_REG,
      RK_STATUS,
      RK_STREAM_INPUT_CONTROL,
      RK_STREAM_OUTPUT_CONTROL
   } tfa_reg_kind_t;

endpackage : tfa_pkg

// ---- tfa_timing.sv ----
// Frame timing generator with per-stream bit alignment and its receive FIFO.
`timescale 1ns/10ps
`include "tfa_cfg.svh"

module tfa_fifo #(
   parameter int W = 21,
   parameter int D = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Filling side
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   // Draining side
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   localparam int AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
   } tfa_fifo_state_t;

   tfa_fifo_state_t st_ff;
   tfa_fifo_state_t nxt_st;
   logic push;
   logic pop;

   assign in_ready = (st_ff.cnt != (AW+1)'(D));
   assign out_valid = (st_ff.cnt != '0);
   assign out_data = st_ff.mem[st_ff.rd];
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.mem[st_ff.wr] = in_data;
         nxt_st.wr = (st_ff.wr == AW'(D-1)) ? '0 : st_ff.wr + AW'(1);
      end
      if (pop) begin
         nxt_st.rd = (st_ff.rd == AW'(D-1)) ? '0 : st_ff.rd + AW'(1);
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

endmodule : tfa_fifo

module tfa_timing
   import tfa_pkg::*;
#(
   parameter int NS = 32,
   parameter int NHZ = 16,
   parameter int FRAME_TICKS = `TFA_FRAME_TICKS,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input tfa_reg_req_t reg_req,
   output logic [15:0] reg_rdata,
   // Serial side inputs
   input wire logic in_frame_pulse,
   input wire logic [NS-1:0] in_stream,
   // Serial side outputs
   output tfa_tim_pins_t tim_pins,
   output logic [NS-1:0] out_stream,
   output logic [NHZ-1:0] ext_hiz_ctrl,
   // Transmit data from the switch core
   input wire logic [NS-1:0][7:0] tx_byte,
   input wire logic [NS-1:0] tx_en,
   // Received channel bytes to the switch core
   output tfa_rx_word_t rx_word,
   output logic rx_valid,
   input wire logic rx_ready
);
   localparam int CW = $clog2(FRAME_TICKS);

   typedef struct packed {
      logic fp_s1;
      logic fp_s2;
      logic fp_d;
      logic [NS-1:0] din_s1;
      logic [NS-1:0] din_s2;
      logic [CW-1:0] t;
      logic [15:0] cr;
      logic [15:0] internal_mode_select_reg;
      logic [15:0] out_clk_frame_select_reg;
      logic overrun;
      logic [NS-1:0][15:0] stream_input_control;
      logic [NS-1:0][15:0] stream_output_control;
      logic [NS-1:0][15:0] stream_input_control_act;
      logic [NS-1:0][15:0] stream_output_control_act;
      logic [NS-1:0][7:0] rx_sh;
      logic [NS-1:0][7:0] rx_hold;
      logic [NS-1:0][7:0] rx_ch;
      logic [NS-1:0] rx_pend;
      logic [NS-1:0][7:0] tx_sh;
      logic [NHZ-1:0] hz_on;
      logic [NS-1:0] dout;
      logic [NHZ-1:0] hiz;
      tfa_tim_pins_t pins;
      logic [15:0] rdata;
      logic rx_valid;
      tfa_rx_word_t rx_word;
   } tfa_state_t;

   function automatic tfa_state_t rst_state();
      tfa_state_t r;
      r = '0;
      for (int i = 0; i < NS; i++) begin
         r.stream_input_control[i] = `TFA_STREAM_INPUT_CONTROL_RST;
         r.stream_input_control_act[i] = `TFA_STREAM_INPUT_CONTROL_RST;
         r.stream_output_control[i] = `TFA_STREAM_OUTPUT_CONTROL_RST;
         r.stream_output_control_act[i] = `TFA_STREAM_OUTPUT_CONTROL_RST;
      end
      r.cr = `TFA_CR_RST;
      r.internal_mode_select_reg = `TFA_IMS_RST;
      r.out_clk_frame_select_reg = `TFA_OUT_CLK_FRAME_SELECT_REG_RST;
      r.hiz = '1;
      return r;
   endfunction : rst_state

   localparam tfa_state_t ST_RST = rst_state();

   // Address decode shared by the write and the read path.
   function automatic tfa_reg_kind_t reg_kind(input logic [13:0] a);
      tfa_reg_kind_t k;
      k = RK_NONE;
      if (a == `TFA_ADDR_CR) k = RK_CR;
      else if (a == `TFA_ADDR_IMS) k = RK_IMS;
      else if (a == `TFA_ADDR_OUT_CLK_FRAME_SELECT_REG) k = RK_OUT_CLK_FRAME_SELECT_REG;
      else if (a == `TFA_ADDR_STATUS) k = RK_STATUS;
      else if ((a & 14'h3FE0) == `TFA_ADDR_STREAM_INPUT_CONTROL && int'(a[4:0]) < NS) k = RK_STREAM_INPUT_CONTROL;
      else if ((a & 14'h3FE0) == `TFA_ADDR_STREAM_OUTPUT_CONTROL && int'(a[4:0]) < NS) k = RK_STREAM_OUTPUT_CONTROL;
      return k;
   endfunction : reg_kind

   // Ticks per bit as a shift: 2.048 Mbps is 32 ticks, 16.384 Mbps is 4 ticks.
   function automatic logic [2:0] bit_shift(input logic [1:0] rate);
      return 3'h5 - {1'b0, rate};
   endfunction : bit_shift

   function automatic logic [CW-1:0] q_ticks(input logic [2:0] q, input logic [2:0] sh);
      logic [CW-1:0] v;
      v = CW'(q);
      return v << (sh - 3'h2);
   endfunction : q_ticks

   tfa_state_t st_ff;
   tfa_state_t nxt_st;
   logic fifo_in_valid;
   logic fifo_in_ready;
   tfa_rx_word_t fifo_in_data;
   logic fifo_out_valid;
   tfa_rx_word_t fifo_out_data;
   logic fifo_out_ready;

   assign fifo_out_ready = ~st_ff.rx_valid | rx_ready;

   always_comb begin : comb_p
      logic [CW-1:0] nt;
      logic [CW-1:0] pos;
      logic [CW-1:0] msk;
      logic [CW-1:0] w;
      logic [2:0] sh;
      logic [2:0] r;
      logic [2:0] hs;
      logic [2:0] q;
      logic [2:0] maxr;
      logic [1:0] rt;
      logic [7:0] cur;
      logic mark;
      logic act;
      logic start;
      logic done;
      tfa_reg_kind_t wk;
      int sel;
      nt = '0;
      pos = '0;
      msk = '0;
      w = '0;
      sh = '0;
      r = '0;
      hs = '0;
      q = '0;
      maxr = '0;
      rt = '0;
      cur = '0;
      mark = 1'b0;
      act = 1'b0;
      start = 1'b0;
      done = 1'b0;
      sel = 0;
      wk = reg_kind(reg_req.addr);
      nxt_st = st_ff;

      nxt_st.fp_s1 = in_frame_pulse;
      nxt_st.fp_s2 = st_ff.fp_s1;
      nxt_st.fp_d = st_ff.fp_s2;
      nxt_st.din_s1 = in_stream;
      nxt_st.din_s2 = st_ff.din_s1;

      // The input frame pulse edge realigns the one frame counter that drives every output.
      mark = st_ff.cr[`TFA_CR_INPOL] ? (st_ff.fp_s2 & ~st_ff.fp_d) : (~st_ff.fp_s2 & st_ff.fp_d);
      if (mark && st_ff.cr[`TFA_CR_INPOS] && st_ff.cr[`TFA_CR_INPOL]) begin
         nt = '0;
      end else if (mark) begin
         nt = CW'(2) << st_ff.cr[`TFA_CR_RATE_LO +: 2];
      end else begin
         nt = (st_ff.t == CW'(FRAME_TICKS - 1)) ? '0 : st_ff.t + CW'(1);
      end
      nxt_st.t = nt;

      if (reg_req.cs && reg_req.wr) begin
         case (wk)
            RK_CR: nxt_st.cr = reg_req.wdata;
            RK_IMS: nxt_st.internal_mode_select_reg = reg_req.wdata;
            RK_OUT_CLK_FRAME_SELECT_REG: nxt_st.out_clk_frame_select_reg = reg_req.wdata;
            RK_STATUS: nxt_st.overrun = st_ff.overrun & ~reg_req.wdata[0];
            RK_STREAM_INPUT_CONTROL: nxt_st.stream_input_control[reg_req.addr[4:0]] = reg_req.wdata & `TFA_STREAM_INPUT_CONTROL_MASK;
            RK_STREAM_OUTPUT_CONTROL: nxt_st.stream_output_control[reg_req.addr[4:0]] = reg_req.wdata & `TFA_STREAM_OUTPUT_CONTROL_MASK;
            default: nxt_st.cr = st_ff.cr;
         endcase
      end

      // Stream settings are copied at the frame boundary so no frame is cut in two.
      if (st_ff.t == '0) begin
         nxt_st.stream_input_control_act = st_ff.stream_input_control;
         nxt_st.stream_output_control_act = st_ff.stream_output_control;
      end

      // Output clocks and frame pulses, computed for the next tick so the pins stay registered.
      case (st_ff.cr[`TFA_CR_RATE_LO +: 2])
         2'h0: maxr = 3'h2;
         2'h1: maxr = 3'h1;
         default: maxr = 3'h0;
      endcase
      for (int k = 0; k < 4; k++) begin
         r = (k == 3) ? {1'b0, st_ff.out_clk_frame_select_reg[`TFA_OC_SEL3_LO +: 2]} : 3'(k);
         hs = 3'h3 - r;
         w = CW'(2) << hs;
         if (st_ff.out_clk_frame_select_reg[`TFA_OC_FPPOS_LO + k]) begin
            act = (nt < w);
         end else begin
            act = ((nt + (w >> 1)) < w);
         end
         if (st_ff.cr[`TFA_CR_DIV] && r > maxr) begin
            nxt_st.pins.clk[k] = 1'b0;
            nxt_st.pins.fp[k] = ~st_ff.out_clk_frame_select_reg[`TFA_OC_FPPOL_LO + k];
         end else begin
            nxt_st.pins.clk[k] = nt[hs] ^ st_ff.out_clk_frame_select_reg[`TFA_OC_CKPOL_LO + k];
            nxt_st.pins.fp[k] = st_ff.out_clk_frame_select_reg[`TFA_OC_FPPOL_LO + k] ? act : ~act;
         end
         nxt_st.pins.clk_oe[k] = st_ff.internal_mode_select_reg[`TFA_IMS_CKEN_LO + k];
         nxt_st.pins.fp_oe[k] = st_ff.internal_mode_select_reg[`TFA_IMS_FPEN_LO + k];
      end

      // One completed byte per cycle leaves for the FIFO, lowest stream first.
      fifo_in_valid = 1'b0;
      fifo_in_data = '0;
      for (int s = NS - 1; s >= 0; s--) begin
         if (st_ff.rx_pend[s]) begin
            fifo_in_valid = 1'b1;
            sel = s;
         end
      end
      fifo_in_data.stream = 5'(sel);
      fifo_in_data.chan = st_ff.rx_ch[sel];
      fifo_in_data.data = st_ff.rx_hold[sel];
      if (fifo_in_valid && fifo_in_ready) begin
         nxt_st.rx_pend[sel] = 1'b0;
      end

      // Input sampling: bit grid shifted by whole bits, then by the sampling point.
      for (int s = 0; s < NS; s++) begin
         rt = st_ff.stream_input_control_act[s][`TFA_SC_RATE_LO +: 2];
         sh = bit_shift(rt);
         if (rt == 2'h3) begin
            q = (st_ff.stream_input_control_act[s][`TFA_SI_SMP_LO +: 2] == 2'h3) ? 3'h4 : 3'h2;
         end else begin
            q = {1'b0, st_ff.stream_input_control_act[s][`TFA_SI_SMP_LO +: 2]} + 3'h1;
         end
         pos = st_ff.t - (CW'(st_ff.stream_input_control_act[s][`TFA_SI_BD_LO +: 3]) << sh) - q_ticks(q, sh) + CW'(1);
         msk = (CW'(1) << sh) - CW'(1);
         if ((pos & msk) == '0) begin
            nxt_st.rx_sh[s] = {st_ff.rx_sh[s][6:0], st_ff.din_s2[s]};
            if (((pos >> sh) & CW'(7)) == CW'(7)) begin
               // A byte still waiting is overwritten; the sticky flag records the loss.
               if (st_ff.rx_pend[s] && !(fifo_in_valid && fifo_in_ready && sel == s)) begin
                  nxt_st.overrun = 1'b1;
               end
               nxt_st.rx_hold[s] = {st_ff.rx_sh[s][6:0], st_ff.din_s2[s]};
               // The shift count is widened so that a 32-tick bit grid does not wrap to zero.
               nxt_st.rx_ch[s] = 8'(pos >> ({1'b0, sh} + 4'h3));
               nxt_st.rx_pend[s] = 1'b1;
            end
         end
      end

      // Output streams run ahead of the boundary by whole and fractional bits.
      for (int s = 0; s < NS; s++) begin
         rt = st_ff.stream_output_control_act[s][`TFA_SC_RATE_LO +: 2];
         sh = bit_shift(rt);
         msk = (CW'(1) << sh) - CW'(1);
         if (rt == 2'h3) begin
            q = st_ff.stream_output_control_act[s][`TFA_SO_FA_LO + 1] ? 3'h2 : 3'h0;
         end else begin
            q = {1'b0, st_ff.stream_output_control_act[s][`TFA_SO_FA_LO +: 2]};
         end
         pos = nt + (CW'(st_ff.stream_output_control_act[s][`TFA_SO_AD_LO +: 3]) << sh) + q_ticks(q, sh);
         start = ((pos & (msk | (CW'(7) << sh))) == '0);
         cur = start ? tx_byte[s] : st_ff.tx_sh[s];
         if (start) begin
            nxt_st.tx_sh[s] = tx_byte[s];
         end
         nxt_st.dout[s] = cur[3'h7 - 3'(pos >> sh)];
         if (s < NHZ) begin
            q = st_ff.stream_output_control_act[s][`TFA_SO_HZ_LO +: 3];
            if (rt == 2'h3) begin
               done = (q == 3'h0) || (q == 3'h2) || (q == 3'h4);
            end else begin
               done = (q <= 3'h4);
            end
            q = done ? q : 3'h0;
            pos = pos + q_ticks(q, sh);
            start = ((pos & (msk | (CW'(7) << sh))) == '0);
            if (start) begin
               nxt_st.hz_on[s] = tx_en[s];
            end
            // High means the external buffer stays off for this channel.
            nxt_st.hiz[s] = ~(start ? tx_en[s] : st_ff.hz_on[s]);
         end
      end

      if (reg_req.cs && !reg_req.wr) begin
         case (wk)
            RK_CR: nxt_st.rdata = st_ff.cr;
            RK_IMS: nxt_st.rdata = st_ff.internal_mode_select_reg;
            RK_OUT_CLK_FRAME_SELECT_REG: nxt_st.rdata = st_ff.out_clk_frame_select_reg;
            RK_STATUS: nxt_st.rdata = {14'h0000, ~fifo_in_ready, st_ff.overrun};
            RK_STREAM_INPUT_CONTROL: nxt_st.rdata = st_ff.stream_input_control[reg_req.addr[4:0]];
            RK_STREAM_OUTPUT_CONTROL: nxt_st.rdata = st_ff.stream_output_control[reg_req.addr[4:0]];
            default: nxt_st.rdata = 16'h0000;
         endcase
      end

      if (fifo_out_ready) begin
         nxt_st.rx_valid = fifo_out_valid;
         nxt_st.rx_word = fifo_out_data;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   tfa_fifo #(
      .W($bits(tfa_rx_word_t)),
      .D(FIFO_DEPTH)
   ) u_rx_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(fifo_in_valid),
      .in_data(fifo_in_data),
      .in_ready(fifo_in_ready),
      .out_valid(fifo_out_valid),
      .out_data(fifo_out_data),
      .out_ready(fifo_out_ready)
   );

   assign reg_rdata = st_ff.rdata;
   assign tim_pins = st_ff.pins;
   assign out_stream = st_ff.dout;
   assign ext_hiz_ctrl = st_ff.hiz;
   assign rx_valid = st_ff.rx_valid;
   assign rx_word = st_ff.rx_word;

endmodule : tfa_timing

// ---- tfa_timing_props.sv ----
// Concurrent checks on the ports of the frame timing block.
`timescale 1ns/10ps
`include "tfa_cfg.svh"
module tfa_timing_props
   import tfa_pkg::*;
#(
   parameter int NS = 32,
   parameter int NHZ = 16,
   parameter int FRAME_TICKS = `TFA_FRAME_TICKS,
   parameter int FIFO_DEPTH = 16
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port
   input tfa_reg_req_t reg_req,
   input wire logic [15:0] reg_rdata,
   // Serial side
   input wire logic in_frame_pulse,
   input wire logic [NS-1:0] in_stream,
   input tfa_tim_pins_t tim_pins,
   input wire logic [NS-1:0] out_stream,
   input wire logic [NHZ-1:0] ext_hiz_ctrl,
   // Switch core side
   input wire logic [NS-1:0][7:0] tx_byte,
   input wire logic [NS-1:0] tx_en,
   input tfa_rx_word_t rx_word,
   input wire logic rx_valid,
   input wire logic rx_ready
);
   logic [1:0] sync_cnt_ff;
   logic seen_ff;
   logic [15:0] gap_ff;
   logic armed;
   // Timing checks wait for two input frame pulses, so the first resync jump is not judged.
   assign armed = sync_cnt_ff[1];
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sync_cnt_ff <= 2'h0;
         seen_ff <= 1'h0;
         gap_ff <= 16'h0000;
      end else begin
         if ($fell(in_frame_pulse) && !armed) begin
            sync_cnt_ff <= sync_cnt_ff + 2'h1;
         end
         if ($fell(tim_pins.fp[0])) begin
            gap_ff <= 16'h0000;
            seen_ff <= armed;
         end else begin
            gap_ff <= gap_ff + 16'h0001;
         end
      end
   end
   a_frame_period: assert property (@(posedge clk_sys) disable iff (!rst_n || !armed)
      $fell(tim_pins.fp[0]) && seen_ff |-> gap_ff == 16'(FRAME_TICKS - 1)) else $error("frame period wrong");
   a_fp0_width: assert property (@(posedge clk_sys) disable iff (!rst_n || !armed)
      $fell(tim_pins.fp[0]) |-> (!tim_pins.fp[0])[*8] ##8 !tim_pins.fp[0] ##1 tim_pins.fp[0])
      else $error("pulse 0 width wrong");
   a_fp1_width: assert property (@(posedge clk_sys) disable iff (!rst_n || !armed)
      $fell(tim_pins.fp[1]) |-> (!tim_pins.fp[1])[*8] ##1 tim_pins.fp[1]) else $error("pulse 1 width wrong");
   a_fp2_width: assert property (@(posedge clk_sys) disable iff (!rst_n || !armed)
      $fell(tim_pins.fp[2]) |-> (!tim_pins.fp[2])[*4] ##1 tim_pins.fp[2]) else $error("pulse 2 width wrong");
   a_boundary_align: assert property (@(posedge clk_sys) disable iff (!rst_n || !armed)
      $fell(tim_pins.fp[0]) |-> ##8 ($fell(tim_pins.clk[0]) && $fell(tim_pins.clk[1]) && $fell(tim_pins.clk[2])
      && !tim_pins.fp[1] && !tim_pins.fp[2])) else $error("boundary edges misaligned");
   a_clk0_half: assert property (@(posedge clk_sys) disable iff (!rst_n || !armed)
      $rose(tim_pins.clk[0]) |-> tim_pins.clk[0][*8] ##1 !tim_pins.clk[0]) else $error("clock 0 half period wrong");
   a_oe_follow: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_req.cs && reg_req.wr && reg_req.addr == `TFA_ADDR_IMS |-> ##2
      tim_pins.fp_oe == $past(reg_req.wdata[11:8], 2) && tim_pins.clk_oe == $past(reg_req.wdata[15:12], 2))
      else $error("output enables wrong");
   a_rx_hold: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_word)) else $error("received word not held");
   a_unmapped_read: assert property (@(posedge clk_sys) disable iff (!rst_n)
      reg_req.cs && !reg_req.wr && reg_req.addr == 14'h0004 |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
endmodule : tfa_timing_props
bind tfa_timing tfa_timing_props #(.NS(NS), .NHZ(NHZ), .FRAME_TICKS(FRAME_TICKS), .FIFO_DEPTH(FIFO_DEPTH)) i_props (
   .clk_sys(clk_sys), .rst_n(rst_n), .reg_req(reg_req), .reg_rdata(reg_rdata), .in_frame_pulse(in_frame_pulse),
   .in_stream(in_stream), .tim_pins(tim_pins), .out_stream(out_stream), .ext_hiz_ctrl(ext_hiz_ctrl),
   .tx_byte(tx_byte), .tx_en(tx_en), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));

// ---- tfa_peer.sv ----
// Peer serial device: input frame pulse source and patterned input streams.
`timescale 1ns/10ps
module tfa_peer
   import tfa_pkg::*;
#(
   parameter int NS = 4,
   parameter int FRAME_TICKS = 2048
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // Timing seen from the block
   input tfa_tim_pins_t tim_pins,
   // Lines towards the block
   output logic in_frame_pulse,
   output logic [NS-1:0] in_stream,
   // Frame position tracked from the block
   output logic [15:0] pt
);
   logic [15:0] fc;
   logic fp0_d;
   logic [7:0] v;
   int b;
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fc <= 16'h0000;
         pt <= 16'h0000;
         fp0_d <= 1'h0;
      end else begin
         fc <= (fc == 16'(FRAME_TICKS - 1)) ? 16'h0000 : fc + 16'h0001;
         pt <= (tim_pins.fp[0] && !fp0_d) ? 16'h0009 : (pt + 16'h0001) % 16'(FRAME_TICKS);
         fp0_d <= tim_pins.fp[0];
      end
   end
   // Free-running source, so later pulses land where the block already is.
   assign in_frame_pulse = !rst_n || (fc < 16'(FRAME_TICKS - 4));
   // Stream s carries the byte pattern late by s bits at 2.048 Mbps, MSB first.
   always_comb begin
      in_stream = '0;
      for (int s = 0; s < NS; s++) begin
         b = (int'(pt) / 32 - s + FRAME_TICKS / 32) % (FRAME_TICKS / 32);
         v = 8'h5A ^ 8'((b / 8) * 17);
         in_stream[s] = rst_n && v[7 - b % 8];
      end
   end
endmodule : tfa_peer

// ---- testbench.sv ----
// Self-checking bench for the frame timing block.
`timescale 1ns/10ps
`include "tfa_cfg.svh"
module testbench;
   import tfa_pkg::*;
   localparam int NS = 4;
   localparam int FT = 2048;
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   tfa_reg_req_t reg_req = '0;
   logic [15:0] reg_rdata;
   logic in_frame_pulse;
   logic [NS-1:0] in_stream;
   tfa_tim_pins_t tim_pins;
   logic [NS-1:0] out_stream;
   logic [3:0] ext_hiz_ctrl;
   logic [NS-1:0][7:0] tx_byte = '0;
   logic [NS-1:0] tx_en = '0;
   tfa_rx_word_t rx_word;
   logic rx_valid;
   logic rx_ready = 1'h1;
   logic [15:0] pt;
   logic stall = 1'h0;
   logic rx_chk = 1'h0;
   logic rd_pend = 1'h0;
   logic [15:0] rd_q[$];
   logic [31:0] rnd = 32'hB59A81AE;
   logic [31:0] rnd2 = 32'hB59A81AE;
   int err_count = 0;
   int total_checks = 0;

   always #25 clk_sys = ~clk_sys;

   tfa_timing #(.NS(NS), .NHZ(4), .FRAME_TICKS(FT), .FIFO_DEPTH(16)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
      .reg_req(reg_req), .reg_rdata(reg_rdata), .in_frame_pulse(in_frame_pulse), .in_stream(in_stream),
      .tim_pins(tim_pins), .out_stream(out_stream), .ext_hiz_ctrl(ext_hiz_ctrl), .tx_byte(tx_byte),
      .tx_en(tx_en), .rx_word(rx_word), .rx_valid(rx_valid), .rx_ready(rx_ready));
   tfa_peer #(.NS(NS), .FRAME_TICKS(FT)) i_peer (.clk_sys(clk_sys), .rst_n(rst_n), .tim_pins(tim_pins),
      .in_frame_pulse(in_frame_pulse), .in_stream(in_stream), .pt(pt));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] pat(input int c);
      return 8'h5A ^ 8'(c * 17);
   endfunction : pat
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic print_verdict();
      if (err_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict
   task automatic reg_acc(input logic wr, input logic [13:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      #2;
      reg_req = {1'h1, wr, a, d};
      if (!wr) begin
         rd_q.push_back(d);
      end
      @(posedge clk_sys);
      #2;
      reg_req.cs = 1'h0;
   endtask : reg_acc
   task automatic wait_pt(input logic [15:0] v);
      for (int i = 0; i < 3 * FT && pt !== v; i++) begin
         @(posedge clk_sys);
         #2;
      end
      if (pt !== v) begin
         err_count++;
         $display("ERROR %0t: timeout", $time);
         print_verdict();
      end
   endtask : wait_pt

   // Read answers and received bytes are judged against the oldest note or the peer pattern.
   always @(posedge clk_sys) begin
      if (rd_pend) begin
         check(reg_rdata, rd_q.pop_front());
      end
      rd_pend = reg_req.cs && !reg_req.wr;
      if (rx_chk && rx_valid && rx_ready) begin
         check(16'(rx_word.data), 16'(pat(int'(rx_word.chan))));
      end
   end
   always @(posedge clk_sys) begin
      #2;
      rnd2 = lfsr(rnd2);
      rx_ready = !stall && rnd2[0];
   end

   initial begin
      logic v;
      repeat (20) @(posedge clk_sys);
      #2;
      rst_n = 1'h1;
      reg_acc(1'h0, `TFA_ADDR_CR, 16'h0000);
      reg_acc(1'h0, `TFA_ADDR_IMS, `TFA_IMS_RST);
      reg_acc(1'h0, `TFA_ADDR_OUT_CLK_FRAME_SELECT_REG, 16'h0000);
      reg_acc(1'h0, `TFA_ADDR_STREAM_INPUT_CONTROL, 16'h0020);
      reg_acc(1'h0, `TFA_ADDR_STREAM_OUTPUT_CONTROL, 16'h0000);
      reg_acc(1'h0, 14'h0004, 16'h0000);
      reg_acc(1'h0, `TFA_ADDR_STREAM_INPUT_CONTROL + 14'(NS), 16'h0000);
      rnd = lfsr(rnd);
      reg_acc(1'h1, `TFA_ADDR_STREAM_OUTPUT_CONTROL + 14'h0003, rnd[15:0]);
      reg_acc(1'h0, `TFA_ADDR_STREAM_OUTPUT_CONTROL + 14'h0003, rnd[15:0] & 16'h0FFF);
      for (int s = 1; s < NS; s++) begin
         reg_acc(1'h1, `TFA_ADDR_STREAM_INPUT_CONTROL + 14'(s), 16'h0020 | 16'(s << 6));
      end
      tx_byte = {rnd[31:16], 8'h00, 8'h80};
      tx_en = 4'hD;
      repeat (3 * FT) @(posedge clk_sys);
      rx_chk = 1'h1;
      wait_pt(16'h0014);
      check(out_stream[0], 1'h1);
      check(ext_hiz_ctrl[1:0], 2'h2);
      wait_pt(16'h00F0);
      check(out_stream[0], 1'h0);
      reg_acc(1'h1, `TFA_ADDR_STREAM_OUTPUT_CONTROL, 16'h0010);
      repeat (2 * FT) @(posedge clk_sys);
      wait_pt(16'h0014);
      check(out_stream[0], 1'h0);
      wait_pt(16'h00DC);
      check(out_stream[0], 1'h0);
      wait_pt(16'h00F0);
      check(out_stream[0], 1'h1);
      reg_acc(1'h1, `TFA_ADDR_STREAM_OUTPUT_CONTROL, 16'h0110);
      repeat (2 * FT) @(posedge clk_sys);
      wait_pt(16'h00DC);
      check(out_stream[0], 1'h1);
      reg_acc(1'h1, `TFA_ADDR_OUT_CLK_FRAME_SELECT_REG, 16'h0088);
      wait_pt(16'h0004);
      check({tim_pins.clk[3], tim_pins.fp[3], tim_pins.fp[0]}, 3'h6);
      reg_acc(1'h1, `TFA_ADDR_OUT_CLK_FRAME_SELECT_REG, 16'h3000);
      wait_pt(16'h0400);
      v = tim_pins.clk[3];
      @(posedge clk_sys);
      #2;
      check(tim_pins.clk[3], !v);
      reg_acc(1'h1, `TFA_ADDR_IMS, 16'h7700);
      @(posedge clk_sys);
      #2;
      check({tim_pins.clk_oe, tim_pins.fp_oe}, 8'h77);
      reg_acc(1'h1, `TFA_ADDR_IMS, 16'hFF00);
      @(posedge clk_sys);
      stall = 1'h1;
      repeat (FT) @(posedge clk_sys);
      reg_acc(1'h0, `TFA_ADDR_STATUS, 16'h0003);
      @(posedge clk_sys);
      stall = 1'h0;
      for (int i = 0; i < 300 && rx_valid !== 1'h0; i++) begin
         @(posedge clk_sys);
         #2;
      end
      check(rx_valid, 1'h0);
      reg_acc(1'h1, `TFA_ADDR_STATUS, 16'h0001);
      reg_acc(1'h0, `TFA_ADDR_STATUS, 16'h0000);
      repeat (4) @(posedge clk_sys);
      print_verdict();
   end
endmodule : testbench
